/* File: hw/adc_ctrl_pkg.sv */
// Purpose: Constants for the serial converter control block
// Assumes: 16-clock serial words, command code in the top four bits
// Notes:   Command codes and field positions are kept here only
// Summary of operation
// - End-of-conversion form only in mode 00
// - Extended start in FIFO modes needs internal reference
// - Decode four clocks, then shift configuration out
// - Configuration read honoured only in mode 00
// - First cycle after interrupt shifts oldest entry
// - Other command stops shift, keeps oldest entry
// - FIFO read starts nothing, no interrupt
// - Back-to-back FIFO reads with frame sync high; here a read pops only with chip select low, one entry per interrupt
// - Write loads configuration, starts no conversion
// - Sampling window excludes chip-select low overlap
// - Single-shot extended converts on start rising edge
// - Eight-entry FIFO, interrupt at threshold
// - Single shot forces threshold of one
// - Conversion lasts fourteen conversion clocks
// - Serial clock divided by 1, 2 or 4
// - Automatic power-down when idle, reference stays
// - Reference 2 V, 4 V or external
// - Code saturates at full and zero scale
// - Mode 01 loses unread data on new select
// - Repeat sweep clears FIFO when not read
// - Power-down clears FIFO, restarts sweep
package adc_ctrl_pkg;
    localparam int          WORD_BITS     = 16;
    localparam int          CMD_BITS      = 4;
    localparam int          CFG_BITS      = 12;
    localparam int          DATA_BITS     = 10;
    localparam int          FIFO_DEPTH    = 8;
    localparam int          CONV_CLOCKS   = 14;
    localparam logic [11:0] CFG_RESET     = 12'h000;
    localparam logic [3:0]  CMD_WRITE_CFG = 4'ha;
    localparam logic [3:0]  CMD_READ_CFG  = 4'h9;
    localparam logic [3:0]  CMD_READ_FIFO = 4'he;
    localparam logic [3:0]  CMD_SW_PDOWN  = 4'h8;
    localparam logic [3:0]  CMD_SEL_LAST  = 4'h7;
    localparam int          CFG_REF_EXT   = 11;
    localparam int          CFG_REF_4V    = 10;
    localparam int          CFG_EOC_SEL   = 2;
    localparam int          CFG_CLK_HI    = 8;
    localparam int          CFG_CLK_LO    = 7;
    localparam int          CFG_MODE_HI   = 6;
    localparam int          CFG_MODE_LO   = 5;
    localparam int          CFG_EXT_SAMP  = 9;
    localparam int          CFG_THR_HI    = 1;
    localparam int          CFG_THR_LO    = 0;
    localparam logic [1:0]  MODE_SINGLE   = 2'h0;
    localparam logic [1:0]  MODE_REPEAT   = 2'h1;
    localparam logic [1:0]  MODE_RSWEEP   = 2'h3;
    localparam real         EXT_WAIT_US   = 2.5;
    localparam real         CLK_MHZ       = 10.0;
    localparam int          EXT_WAIT_CYC  = int'($floor(EXT_WAIT_US * CLK_MHZ));
    localparam int          SELECT_MIN    = 6;
endpackage

/* File: hw/adc_serial_fifo_control.sv */
`timescale 1ns/1ps
// Purpose: Serial command, conversion timing and FIFO control
// Assumes: Serial pins sampled into clk_sys, data rising edge
// Notes:   The analog result arrives on resultCode when done
module adc_serial_fifo_control
    import adc_ctrl_pkg::*;
(
    input  wire logic       clk_sys,
    input  wire logic       resetn,
    input  wire logic       clkEn,
    input  wire logic       chip_select_n,
    input  wire logic       frame_sync,
    input  wire logic       serial_clk,
    input  wire logic       serial_in,
    input  wire logic       conversion_start_n,
    input  wire logic       hard_power_down_n,
    input  wire logic       osc_tick,
    input  wire logic [9:0] resultCode,
    output logic            serial_out,
    output logic            serial_out_en,
    output logic            eocIntPin,
    output logic            convActive,
    output logic            sampleActive,
    output logic            poweredUp,
    output logic [1:0]      refSelect,
    output logic [3:0]      channel,
    output logic            startSample
);
    typedef enum {IDLE, SAMPLE, CONVERT} conv_state_type;

    logic [2:0]     csSync;
    logic [2:0]     fsSync;
    logic [2:0]     sckSync;
    logic [2:0]     cstSync;
    logic [1:0]     sdiSync;
    logic [1:0]     pdSync;
    logic [11:0]    converter_configuration;
    logic [15:0]    shiftIn;
    logic [15:0]    shiftOut;
    logic [4:0]     bitCount;
    logic           irqPending;
    logic           fifoCycle;
    logic           readHold;
    logic [3:0]     convCount;
    logic [1:0]     divCount;
    logic           extWait;
    conv_state_type state;
    fifo_port_if    fifoPort ();

    function automatic logic [3:0] thresholdOf(input logic [11:0] cfg);
        if (cfg[CFG_MODE_HI:CFG_MODE_LO] == MODE_SINGLE)
            return 4'h1;
        unique case (cfg[CFG_THR_HI:CFG_THR_LO])
            2'h0: return 4'h8;
            2'h1: return 4'h6;
            2'h2: return 4'h4;
            2'h3: return 4'h2;
        endcase
    endfunction

    function automatic logic [3:0] divOf(input logic [1:0] sel);
        return (sel == 2'h2) ? 4'h1 : (sel == 2'h3) ? 4'h4 : 4'h2;
    endfunction

    logic       active;
    logic       sckRise;
    logic       sckFall;
    logic       csFall;
    logic       cstRise;
    logic       cstFall;
    logic       wordDone;
    logic [3:0] cmd;
    logic [3:0] earlyCmd;
    logic [1:0] mode;
    logic       convTick;

    assign active   = !csSync[1] || fsSync[1];
    assign sckRise  = sckSync[1] && !sckSync[2];
    assign sckFall  = !sckSync[1] && sckSync[2];
    assign csFall   = !csSync[1] && csSync[2];
    assign cstRise  = cstSync[1] && !cstSync[2];
    assign cstFall  = !cstSync[1] && cstSync[2];
    assign mode     = converter_configuration[CFG_MODE_HI:CFG_MODE_LO];
    assign cmd      = shiftIn[14:11];
    assign earlyCmd = {shiftIn[2:0], sdiSync[1]};
    assign wordDone = sckRise && bitCount == 5'(WORD_BITS - 1) && !csSync[1];

    ////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            csSync  <= 3'h7;
            fsSync  <= 3'h0;
            sckSync <= 3'h0;
            cstSync <= 3'h7;
            sdiSync <= 2'h0;
            pdSync  <= 2'h3;
        end else if (clkEn) begin
            csSync  <= {csSync[1:0], chip_select_n};
            fsSync  <= {fsSync[1:0], frame_sync};
            sckSync <= {sckSync[1:0], serial_clk};
            cstSync <= {cstSync[1:0], conversion_start_n};
            sdiSync <= {sdiSync[0], serial_in};
            pdSync  <= {pdSync[0], hard_power_down_n};
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Input shift and bit counter; frame sync high allows
    // words to follow with only the serial clock
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            shiftIn  <= 16'h0000;
            bitCount <= 5'h00;
        end else if (clkEn) begin
            if (csSync[1] && !fsSync[1]) begin
                bitCount <= 5'h00;
            end else if (sckRise) begin
                shiftIn  <= {shiftIn[14:0], sdiSync[1]};
                bitCount <= (bitCount == 5'(WORD_BITS - 1)) ? 5'h00 : bitCount + 5'h01;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Configuration write and command decode
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            converter_configuration <= CFG_RESET;
            channel                 <= 4'h0;
        end else if (clkEn && (wordDone || (sckRise && bitCount == 5'(WORD_BITS - 1)))) begin
            if (cmd == CMD_WRITE_CFG)
                converter_configuration <= {shiftIn[10:0], sdiSync[1]};
            else if (cmd <= CMD_SEL_LAST)
                channel <= cmd;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Output shift: FIFO entry leads, configuration after four clocks
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            shiftOut      <= 16'h0000;
            serial_out    <= 1'b0;
            serial_out_en <= 1'b0;
            fifoCycle     <= 1'b0;
        end else if (clkEn) begin
            serial_out_en <= active;
            if (csFall || (active && bitCount == 5'h00 && sckFall)) begin
                fifoCycle <= irqPending || readHold;
                shiftOut  <= {fifoPort.rdata, 6'h00};
            end else if (sckRise && bitCount == 5'(CMD_BITS - 1)) begin
                // Command is only complete with the bit now arriving
                if (fifoCycle && earlyCmd != CMD_READ_FIFO)
                    shiftOut <= 16'h0000;
                else if (!fifoCycle && earlyCmd == CMD_READ_CFG && mode == MODE_SINGLE)
                    shiftOut <= {1'b0, converter_configuration, 3'h0};
                else if (!fifoCycle)
                    shiftOut <= 16'h0000;
            end else if (sckFall) begin
                shiftOut <= {shiftOut[14:0], 1'b0};
            end
            serial_out <= shiftOut[15];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // FIFO reads, interrupt and clearing
    assign fifoPort.pop   = wordDone && fifoCycle && cmd == CMD_READ_FIFO;
    assign fifoPort.flush = !pdSync[1] || (wordDone && cmd == CMD_SW_PDOWN)
        || (wordDone && mode == MODE_REPEAT && cmd <= CMD_SEL_LAST)
        || (mode == MODE_RSWEEP && irqPending
            && ((wordDone && cmd != CMD_READ_FIFO) || cstFall));
    assign fifoPort.wdata = resultCode;

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            irqPending <= 1'b0;
            readHold   <= 1'b0;
        end else if (clkEn) begin
            if (fifoPort.push && fifoPort.count + 4'h1 >= thresholdOf(converter_configuration))
                irqPending <= 1'b1;
            else if (fifoPort.flush || (wordDone && fifoCycle))
                irqPending <= 1'b0;
            if (wordDone && fifoCycle && cmd != CMD_READ_FIFO)
                readHold <= 1'b1;
            else if (fifoPort.pop || fifoPort.flush)
                readHold <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Conversion clock: oscillator or divided serial clock
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn)
            divCount <= 2'h0;
        else if (clkEn && sckRise)
            divCount <= (4'(divCount) + 4'h1 >= divOf(converter_configuration[CFG_CLK_HI:CFG_CLK_LO]))
                ? 2'h0 : divCount + 2'h1;
    end
    assign convTick = converter_configuration[CFG_CLK_HI:CFG_CLK_LO] == 2'h0 ? osc_tick
        : (sckRise && 4'(divCount) + 4'h1 >= divOf(converter_configuration[CFG_CLK_HI:CFG_CLK_LO]));

    ////////////////////////////////////////////////////////////////////
    // Sampling and conversion sequencer
    logic extOk;
    logic selDone;
    assign extOk   = converter_configuration[CFG_EXT_SAMP]
        && (mode == MODE_SINGLE || !converter_configuration[CFG_REF_EXT]);
    assign selDone = wordDone && cmd <= CMD_SEL_LAST;

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            state        <= IDLE;
            convCount    <= 4'h0;
            extWait      <= 1'b0;
            startSample  <= 1'b0;
            sampleActive <= 1'b0;
            convActive   <= 1'b0;
            fifoPort.push <= 1'b0;
        end else if (clkEn) begin
            fifoPort.push <= 1'b0;
            startSample   <= 1'b0;
            if (!pdSync[1]) begin
                state <= IDLE;
            end else begin
                unique case (state)
                    IDLE: begin
                        if (selDone && !extOk) begin
                            state       <= SAMPLE;
                            startSample <= 1'b1;
                        end else if (selDone)
                            extWait <= 1'b1;
                        else if (extWait && cstRise && csSync[1]) begin
                            extWait   <= mode != MODE_SINGLE;
                            state     <= CONVERT;
                            convCount <= 4'h0;
                        end
                    end
                    SAMPLE: begin
                        state     <= CONVERT;
                        convCount <= 4'h0;
                    end
                    CONVERT: begin
                        if (convTick) begin
                            if (convCount == 4'(CONV_CLOCKS - 1)) begin
                                state         <= IDLE;
                                fifoPort.push <= 1'b1;
                            end else
                                convCount <= convCount + 4'h1;
                        end
                    end
                endcase
            end
            sampleActive <= extWait && !cstSync[1] && csSync[1];
            convActive   <= state == CONVERT;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Pin form, power and reference steering
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            eocIntPin <= 1'b1;
            poweredUp <= 1'b0;
            refSelect <= 2'h0;
        end else if (clkEn) begin
            if (mode == MODE_SINGLE && converter_configuration[CFG_EOC_SEL])
                eocIntPin <= state != CONVERT;
            else
                eocIntPin <= !irqPending;
            poweredUp <= active || !cstSync[1] || state != IDLE;
            refSelect <= {converter_configuration[CFG_REF_EXT],
                          converter_configuration[CFG_REF_4V]};
        end
    end

    result_fifo #(.DEPTH(FIFO_DEPTH)) store (
        .clk_sys (clk_sys),
        .resetn  (resetn),
        .clkEn   (clkEn),
        .port    (fifoPort)
    );

    chk_cfg_read_mode: assert property (@(posedge clk_sys) disable iff (!resetn)
        mode != MODE_SINGLE && !fifoCycle && clkEn && sckRise && bitCount == 5'(CMD_BITS - 1)
        |=> shiftOut == 16'h0000) else $error("config read outside single shot");
    chk_conv_length: assert property (@(posedge clk_sys) disable iff (!resetn)
        fifoPort.push |-> $past(convCount) == 4'(CONV_CLOCKS - 1))
        else $error("conversion length wrong");
    chk_fifo_bound: assert property (@(posedge clk_sys) disable iff (!resetn)
        fifoPort.count <= 4'(FIFO_DEPTH)) else $error("fifo count overflow");
    chk_pdown_flush: assert property (@(posedge clk_sys) disable iff (!resetn)
        clkEn && !pdSync[1] |=> fifoPort.count == 4'h0) else $error("fifo kept in power down");
    chk_eoc_form: assert property (@(posedge clk_sys) disable iff (!resetn)
        clkEn && mode != MODE_SINGLE && !irqPending |=> eocIntPin)
        else $error("eoc form outside mode 00");
    chk_read_no_conv: assert property (@(posedge clk_sys) disable iff (!resetn)
        state == IDLE && wordDone && cmd == CMD_READ_FIFO |=> state == IDLE)
        else $error("fifo read started conversion");
    chk_write_no_conv: assert property (@(posedge clk_sys) disable iff (!resetn)
        state == IDLE && wordDone && cmd == CMD_WRITE_CFG |=> state == IDLE)
        else $error("write started conversion");
    chk_single_thresh: assert property (@(posedge clk_sys) disable iff (!resetn)
        clkEn && mode == MODE_SINGLE && fifoPort.push |=> irqPending)
        else $error("single shot threshold not one");
endmodule

/* File: hw/fifo_port_if.sv */
`timescale 1ns/1ps
// Purpose: Carrier between control and result store
// Assumes: One clock domain
// Notes:   Control drives requests, store drives state
interface fifo_port_if;
    logic       push;
    logic       pop;
    logic       flush;
    logic [9:0] wdata;
    logic [9:0] rdata;
    logic [3:0] count;
    modport ctrl  (output push, pop, flush, wdata, input rdata, count);
    modport store (input push, pop, flush, wdata, output rdata, count);
endinterface

/* File: hw/result_fifo.sv */
`timescale 1ns/1ps
// Purpose: Eight-entry result store with pointers and count
// Assumes: Flush has priority over push and pop
// Notes:   Pop on empty keeps the last entry on the output
module result_fifo
    import adc_ctrl_pkg::*;
#(
    parameter int DEPTH = FIFO_DEPTH
) (
    input wire logic   clk_sys,
    input wire logic   resetn,
    input wire logic   clkEn,
    fifo_port_if.store port
);
    logic [9:0] mem [DEPTH];
    logic [2:0] wrPtr;
    logic [2:0] rdPtr;
    logic       doPush;
    logic       doPop;

    // Accepted push and pop; a refused push must not block a pop
    assign doPush = port.push && port.count < 4'(DEPTH);
    assign doPop  = port.pop && port.count != 4'h0;

    // Pointer and count update
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            wrPtr      <= 3'h0;
            rdPtr      <= 3'h0;
            port.count <= 4'h0;
        end else if (clkEn) begin
            if (port.flush) begin
                wrPtr      <= 3'h0;
                rdPtr      <= 3'h0;
                port.count <= 4'h0;
            end else begin
                if (port.push && port.count < 4'(DEPTH))
                    wrPtr <= wrPtr + 3'h1;
                if (port.pop && port.count != 4'h0)
                    rdPtr <= rdPtr + 3'h1;
                if (doPush && !doPop)
                    port.count <= port.count + 4'h1;
                else if (doPop && !doPush)
                    port.count <= port.count - 4'h1;
            end
        end
    end

    // Storage write
    always_ff @(posedge clk_sys) begin
        if (clkEn && port.push && !port.flush && port.count < 4'(DEPTH))
            mem[wrPtr] <= port.wdata;
    end

    // Output stays on the last entry when empty
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn)
            port.rdata <= 10'h000;
        else if (clkEn && port.count != 4'h0)
            port.rdata <= mem[rdPtr];
    end
endmodule

/* File: verif/adc_serial_fifo_control_test.sv */
// Purpose: Self-checking bench for the serial converter control
// Assumes: Internal oscillator ticks every four system clocks
// Notes:   Expected words are queued and matched as words complete
`timescale 1ns/1ps
module adc_serial_fifo_control_test;
    import adc_ctrl_pkg::*;
    typedef struct {string name; logic [15:0] mask; logic [15:0] value;} note_type;
    logic        clk_sys, resetn, clkEn, hard_power_down_n, osc_tick;
    logic        chip_select_n, frame_sync, serial_clk, serial_in, conversion_start_n;
    logic [9:0]  resultCode;
    logic        serial_out, serial_out_en, eocIntPin, convActive, sampleActive;
    logic        poweredUp, startSample, wordDone, oscPrev;
    logic [1:0]  refSelect, oscCnt;
    logic [3:0]  channel, tickCnt, lastTicks;
    logic [15:0] rxWord;
    logic [7:0]  seed;
    note_type    notes[$];
    int          nFail, compares, convDone, nStart;

    adc_serial_fifo_control uut (.clk_sys(clk_sys), .resetn(resetn), .clkEn(clkEn),
        .chip_select_n(chip_select_n), .frame_sync(frame_sync), .serial_clk(serial_clk),
        .serial_in(serial_in), .conversion_start_n(conversion_start_n),
        .hard_power_down_n(hard_power_down_n), .osc_tick(osc_tick), .resultCode(resultCode),
        .serial_out(serial_out), .serial_out_en(serial_out_en), .eocIntPin(eocIntPin),
        .convActive(convActive), .sampleActive(sampleActive), .poweredUp(poweredUp),
        .refSelect(refSelect), .channel(channel), .startSample(startSample));
    host_serial_model host (.clk_sys(clk_sys), .serial_out(serial_out),
        .serial_out_en(serial_out_en), .chip_select_n(chip_select_n),
        .frame_sync(frame_sync), .serial_clk(serial_clk), .serial_in(serial_in),
        .wordDone(wordDone), .rxWord(rxWord));

    ////////////////////////////////////////////////////////////////////////////////
    // Clock, 100 ns period
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end

    // Oscillator ticks and conversion length measurement
    always @(posedge clk_sys) begin
        oscCnt <= oscCnt + 2'h1;
        osc_tick <= (oscCnt == 2'h3);
        oscPrev <= osc_tick; // Tick seen by the design one edge earlier
        if (startSample === 1'b1) nStart <= nStart + 1;
        if (convActive === 1'b1) begin
            if (oscPrev) tickCnt <= tickCnt + 4'h1;
        end else if (tickCnt != 4'h0) begin
            lastTicks <= tickCnt;
            tickCnt <= 4'h0;
            convDone <= convDone + 1;
        end
    end

    // Oldest note is matched against each finished word
    always @(posedge clk_sys) begin
        if (wordDone === 1'b1 && notes.size() > 0) check_word(notes.pop_front(), rxWord);
    end

    // Watchdog cuts a hang short
    initial begin
        repeat (40000) @(posedge clk_sys);
        nFail++;
        $display("watchdog expired");
        wrap_up();
    end

    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction

    task automatic check_word(input note_type n, input logic [15:0] got);
        if (n.mask != 16'h0000) begin
            compares++;
            if ((got & n.mask) !== (n.value & n.mask)) begin
                nFail++;
                $display("wrong value %s expected %h seen %h", n.name, n.value & n.mask,
                         got & n.mask);
            end
        end
    endtask

    task automatic check_val(input string name, input logic [15:0] exp, input logic [15:0] got);
        compares++;
        if (got !== exp) begin
            nFail++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic send(input string name, input logic [15:0] tx, input logic [15:0] mask,
                        input logic [15:0] exp);
        notes.push_back('{name, mask, exp});
        host.xfer(tx);
    endtask

    task automatic wrap_up();
        $display("compares %0d mismatches %0d", compares, nFail);
        if (nFail == 0 && compares > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        logic [11:0] cfg;
        logic [3:0]  ch;
        logic [9:0]  code;
        int          k0;
        resetn = 1'b0;
        clkEn = 1'b1;
        hard_power_down_n = 1'b1;
        conversion_start_n = 1'b1;
        resultCode = 10'h000;
        seed = 8'h50;
        oscCnt = 2'h0;
        osc_tick = 1'b0;
        tickCnt = 4'h0;
        lastTicks = 4'h0;
        convDone = 0;
        nStart = 0;
        oscPrev = 1'b0;
        nFail = 0;
        compares = 0;
        repeat (20) @(posedge clk_sys);
        resetn <= 1'b1;
        repeat (4) @(posedge clk_sys);
        check_val("eoc after reset", 16'h0001, {15'h0, eocIntPin});
        for (int k = 0; k < 4; k++) begin
            seed = lfsr(seed);
            cfg = {k[1:0], 5'h00, seed[4:3], 1'b0, seed[1:0]};
            send("write cfg", {CMD_WRITE_CFG, cfg}, 16'h0, 16'h0);
            check_val("ref select", {14'h0, k[1:0]}, {14'h0, refSelect});
            check_val("eoc after write", 16'h0001, {15'h0, eocIntPin});
            check_val("conv after write", 16'h0000, {15'h0, convActive});
            send("read cfg", {CMD_READ_CFG, 12'h000}, 16'h0fff, {4'h0, cfg});
        end
        $display("configuration test done");
        send("write cfg", {CMD_WRITE_CFG, 12'h020}, 16'h0, 16'h0);
        send("read cfg mode 01", {CMD_READ_CFG, 12'h000}, 16'h0fff, 16'h0000);
        $display("refused read test done");
        for (int it = 0; it < 3; it++) begin
            cfg = (it == 0) ? 12'h004 : (it == 1) ? 12'h000 : 12'h200;
            send("write cfg", {CMD_WRITE_CFG, cfg}, 16'h0, 16'h0);
            seed = lfsr(seed);
            code = {seed, seed[7:6]};
            ch = {1'b0, seed[2:0]};
            resultCode <= code;
            k0 = convDone;
            fork
                send("select", {ch, 12'h000}, 16'h0, 16'h0);
                if (it == 2) begin
                    repeat (20) @(posedge clk_sys);
                    conversion_start_n <= 1'b0;
                end
            join
            check_val("channel", {12'h0, ch}, {12'h0, channel});
            if (it == 2) begin
                check_val("sample window", 16'h0001, {15'h0, sampleActive});
                check_val("no early start", 16'h0000, {15'h0, convActive});
                conversion_start_n <= 1'b1;
            end
            for (int w = 0; w < 2000 && convActive !== 1'b1 && convDone == k0; w++)
                @(posedge clk_sys);
            if (it == 0 && convActive === 1'b1)
                check_val("eoc form", 16'h0000, {15'h0, eocIntPin});
            check_val("awake in conversion", 16'h0001, {15'h0, poweredUp});
            for (int w = 0; w < 2000 && convDone == k0; w++) @(posedge clk_sys);
            check_val("conversion ticks", 16'(CONV_CLOCKS), {12'h0, lastTicks});
            repeat (4) @(posedge clk_sys);
            if (it == 1) begin
                check_val("interrupt at one entry", 16'h0000, {15'h0, eocIntPin});
                send("other first", {CMD_READ_CFG, 12'h000}, 16'h0fff, 16'h0000);
            end
            send("fifo read", {CMD_READ_FIFO, 12'h000}, 16'hffc0, {code, 6'h00});
            check_val("no conversion on read", 16'h0000, {15'h0, convActive});
            check_val("eoc after read", 16'h0001, {15'h0, eocIntPin});
            check_val("auto power down", 16'h0000, {15'h0, poweredUp});
        end
        check_val("sample starts", 16'h0002, 16'(nStart));
        $display("conversion test done");
        send("write cfg", {CMD_WRITE_CFG, 12'h400}, 16'h0, 16'h0);
        send("soft power down", {CMD_SW_PDOWN, 12'h000}, 16'h0, 16'h0);
        send("cfg after soft down", {CMD_READ_CFG, 12'h000}, 16'h0fff, 16'h0400);
        hard_power_down_n <= 1'b0;
        repeat (10) @(posedge clk_sys);
        hard_power_down_n <= 1'b1;
        repeat (4) @(posedge clk_sys);
        send("cfg after pin down", {CMD_READ_CFG, 12'h000}, 16'h0fff, 16'h0400);
        $display("power down test done");
        repeat (10) @(posedge clk_sys);
        wrap_up();
    end
endmodule

/* File: verif/host_serial_model.sv */
// Purpose: Host serial port model that frames 16-clock words
// Assumes: Chip-select framing, serial clock low between words
// Notes:   Serial clock half period is HALF system clocks
`timescale 1ns/1ps
module host_serial_model #(
    parameter int HALF = 8
) (
    input  wire logic        clk_sys,
    input  wire logic        serial_out,
    input  wire logic        serial_out_en,
    output logic             chip_select_n,
    output logic             frame_sync,
    output logic             serial_clk,
    output logic             serial_in,
    output logic             wordDone,
    output logic [15:0]      rxWord
);
    logic lastBit;

    ////////////////////////////////////////////////////////////////////////////////
    // Idle levels at time zero
    initial begin
        chip_select_n = 1'b1;
        frame_sync = 1'b0;
        serial_clk = 1'b0;
        serial_in = 1'b0;
        wordDone = 1'b0;
        rxWord = 16'h0000;
        lastBit = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // One word, most significant bit first, command in the top nibble
    task automatic xfer(input logic [15:0] tx);
        logic [15:0] rx;
        @(posedge clk_sys);
        chip_select_n <= 1'b0;
        for (int i = 15; i >= 0; i--) begin
            serial_in <= tx[i];
            repeat (HALF) @(posedge clk_sys);
            serial_clk <= 1'b1;
            rx[i] = serial_out_en ? serial_out : ~lastBit;
            lastBit = rx[i];
            repeat (HALF) @(posedge clk_sys);
            serial_clk <= 1'b0;
        end
        repeat (HALF) @(posedge clk_sys);
        chip_select_n <= 1'b1;
        serial_in <= ~serial_in; // Released line shows no stale bit
        rxWord <= rx;
        wordDone <= 1'b1;
        @(posedge clk_sys);
        wordDone <= 1'b0;
        repeat (HALF) @(posedge clk_sys);
    endtask
endmodule
